/* hw/hmw_cmd_top.sv */
// module: decoder and executor of host write commands on the ascii link
`timescale 1ns/1ps
module hmw_cmd_top (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic rxValid,
  input wire logic [7:0] rxData,
  output logic rxReady,
  output logic txValid,
  output logic [7:0] txData,
  input wire logic txReady,
  output hmw_pkg::hmw_wr_t wrEvt,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  typedef enum logic [8:0] {
    S_IDLE = 9'h001,
    S_HDR1 = 9'h002,
    S_HDR2 = 9'h004,
    S_MODE = 9'h008,
    S_ADDR = 9'h010,
    S_CNT = 9'h020,
    S_DATA = 9'h040,
    S_SKIP = 9'h080,
    S_RESP = 9'h100
  } hmw_state_t;

  hmw_state_t state; // parser state
  hmw_pkg::hmw_kind_t kind; // command being parsed
  hmw_pkg::hmw_op_t attr; // write attribute
  logic csum; // checksum trails the data
  logic single; // one item, no count field
  logic [1:0] digCnt; // digit position in a field
  logic [16:0] addr; // first word or table number
  logic [6:0] cnt; // item count
  logic respEn; // acknowledgement switch
  logic [7:0] doneCnt; // completed frames
  logic [7:0] errCnt; // rejected frames
  logic [39:0] acc; // hex accumulator, data plus checksum
  logic [3:0] nd; // hex digits in current item
  logic [6:0] idx; // item index within frame
  logic [3:0] hiNib; // first nibble of a string byte
  logic nibPhase; // second nibble of a byte expected
  logic [7:0] pend; // string byte held back one step
  logic havePend; // pend holds a byte
  logic [2:0] txIdx; // response byte position
  logic [15:0] wordMem [0:hmw_pkg::WORD_DEPTH-1]; // word memory

  logic rxFire; // a byte is taken
  logic isBcd; // byte is a decimal digit
  logic isHex; // byte is a hex digit
  logic [3:0] nib; // digit value
  logic modeOk; // mode digit legal for kind
  logic [16:0] addrNext; // address with this digit added
  logic [6:0] cntNext; // count with this digit added
  logic fault; // byte is illegal here
  logic endFrame; // good CR ends the frame
  logic txDone; // last response byte taken
  logic itemEnd; // comma or CR closes an item
  logic itemHas; // closed item carries data digits
  logic [31:0] itemVal; // closed item value
  logic [16:0] itemAddr; // target of the closed item
  logic [6:0] bitRem; // tables left from this group on
  logic [15:0] curWord; // present word contents
  logic [15:0] newWord; // word after attribute
  logic [7:0] rxByte; // string byte completed now
  logic apbSetup; // setup phase of a transfer
  logic apbHit; // address maps to a register

  // ---------------------------------------------------------------
  // character classification
  // ---------------------------------------------------------------
  assign rxFire = rxValid && rxReady;
  assign isBcd = rxData >= hmw_pkg::CH_ZERO && rxData <= hmw_pkg::CH_NINE;

  // hex digits in either letter case
  always_comb begin
    isHex = isBcd;
    nib = rxData[3:0];
    if ((rxData >= hmw_pkg::CH_UA && rxData <= hmw_pkg::CH_UF) ||
        (rxData >= hmw_pkg::CH_LA && rxData <= hmw_pkg::CH_LF)) begin
      isHex = 1'b1;
      nib = rxData[3:0] + hmw_pkg::ALPHA_ADJ;
    end
  end

  // bcd accumulation of address and count fields
  assign addrNext = 17'(addr * 17'h0000a) + 17'(nib);
  assign cntNext = 7'(cnt * 7'h0a) + 7'(nib);

  // ---------------------------------------------------------------
  // legality of the current byte
  // ---------------------------------------------------------------
  always_comb begin
    modeOk = 1'b0;
    unique case (kind)
      hmw_pkg::K_WORD: modeOk = 1'b1;
      hmw_pkg::K_NUM: modeOk = nib[2:1] == 2'h0;
      hmw_pkg::K_BIT: modeOk = nib[2:1] == 2'h0;
      hmw_pkg::K_STR: modeOk = nib[3:1] == 3'h0;
    endcase
    fault = 1'b0;
    unique case (state)
      S_HDR1: fault = rxData != hmw_pkg::CH_W;
      S_HDR2: begin
        fault = !(rxData == hmw_pkg::CH_M || rxData == hmw_pkg::CH_N ||
                  rxData == hmw_pkg::CH_S || rxData == hmw_pkg::CH_B);
      end
      S_MODE: fault = !isBcd || !modeOk;
      S_ADDR: begin
        fault = !isBcd;
        if (digCnt == hmw_pkg::ADDR_LAST) begin
          unique case (kind)
            hmw_pkg::K_WORD: fault = fault || addrNext > hmw_pkg::WORD_MAX;
            hmw_pkg::K_NUM: fault = fault || addrNext > hmw_pkg::NUM_MAX;
            hmw_pkg::K_STR: fault = fault || addrNext > hmw_pkg::STR_MAX;
            hmw_pkg::K_BIT: fault = fault || addrNext > hmw_pkg::BIT_MAX;
          endcase
        end
      end
      S_CNT: begin
        fault = !isBcd;
        if (digCnt == hmw_pkg::CNT_LAST) begin
          unique case (kind)
            hmw_pkg::K_WORD: begin
              fault = fault || cntNext == 7'h00 ||
                      cntNext > hmw_pkg::WORD_CNT_MAX;
            end
            hmw_pkg::K_NUM: begin
              fault = fault || cntNext == 7'h00 ||
                      cntNext > hmw_pkg::NUM_CNT_MAX;
            end
            hmw_pkg::K_STR: fault = 1'b1;
            hmw_pkg::K_BIT: fault = fault;
          endcase
        end
      end
      S_DATA: begin
        fault = !(isHex || rxData == hmw_pkg::CH_COMMA ||
                  rxData == hmw_pkg::CH_CR);
      end
      default: fault = 1'b0;
    endcase
  end

  assign endFrame = rxFire && state == S_DATA && rxData == hmw_pkg::CH_CR;
  assign txDone = txValid && txReady && txIdx == hmw_pkg::RESP_LAST;

  // ---------------------------------------------------------------
  // frame parser
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state <= S_IDLE;
      kind <= hmw_pkg::K_WORD;
      attr <= hmw_pkg::OP_SET;
      csum <= 1'b0;
      single <= 1'b0;
      digCnt <= 2'h0;
      addr <= 17'h00000;
      cnt <= 7'h00;
      rxReady <= 1'b1;
      doneCnt <= 8'h00;
      errCnt <= 8'h00;
    end else if (state == S_RESP) begin
      // input is stalled until the acknowledgement is out
      if (txDone) begin
        state <= S_IDLE;
        rxReady <= 1'b1;
      end
    end else if (rxFire && rxData == hmw_pkg::CH_ESC) begin
      state <= S_HDR1;
    end else if (rxFire && state == S_SKIP) begin
      if (rxData == hmw_pkg::CH_CR) begin
        state <= S_IDLE;
      end
    end else if (rxFire && fault && state != S_IDLE) begin
      // bad frame: drop to the next CR with no acknowledgement
      state <= S_SKIP;
      errCnt <= errCnt + 8'h01;
    end else if (rxFire) begin
      unique case (state)
        S_IDLE: state <= S_IDLE;
        S_HDR1: state <= S_HDR2;
        S_HDR2: begin
          state <= S_MODE;
          if (rxData == hmw_pkg::CH_M) begin
            kind <= hmw_pkg::K_WORD;
          end else if (rxData == hmw_pkg::CH_N) begin
            kind <= hmw_pkg::K_NUM;
          end else if (rxData == hmw_pkg::CH_S) begin
            kind <= hmw_pkg::K_STR;
          end else begin
            kind <= hmw_pkg::K_BIT;
          end
        end
        S_MODE: begin
          // odd digit means a checksum, 8 and 9 mean one item
          csum <= nib[0];
          single <= nib[3];
          attr <= nib[3] ? hmw_pkg::OP_SET : hmw_pkg::hmw_op_t'(nib[2:1]);
          addr <= 17'h00000;
          digCnt <= 2'h0;
          state <= S_ADDR;
        end
        S_ADDR: begin
          addr <= addrNext;
          digCnt <= digCnt + 2'h1;
          cnt <= 7'h01;
          if (digCnt == hmw_pkg::ADDR_LAST) begin
            digCnt <= 2'h0;
            cnt <= single ? 7'h01 : 7'h00;
            state <= (single || kind == hmw_pkg::K_STR) ? S_DATA : S_CNT;
          end
        end
        S_CNT: begin
          cnt <= cntNext;
          digCnt <= digCnt + 2'h1;
          if (digCnt == hmw_pkg::CNT_LAST) begin
            if (kind == hmw_pkg::K_BIT && cntNext == 7'h00) begin
              cnt <= hmw_pkg::BIT_CNT_ZERO;
            end
            state <= S_DATA;
          end
        end
        S_DATA: begin
          if (rxData == hmw_pkg::CH_CR) begin
            doneCnt <= doneCnt + 8'h01;
            state <= respEn ? S_RESP : S_IDLE;
            rxReady <= !respEn;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // item values
  // ---------------------------------------------------------------
  assign itemEnd = rxFire && state == S_DATA && !fault &&
                   (rxData == hmw_pkg::CH_COMMA || rxData == hmw_pkg::CH_CR);

  // with a checksum the last two digits before CR are not data
  always_comb begin
    itemHas = nd != 4'h0;
    itemVal = acc[31:0];
    if (csum && rxData == hmw_pkg::CH_CR) begin
      itemHas = nd > hmw_pkg::CS_DIGITS;
      itemVal = acc[39:8];
    end
  end

  // word and numeral tables step by one, bit tables by groups; string writes keep one table
  always_comb begin
    itemAddr = addr + 17'(idx);
    bitRem = cnt - 7'(idx * hmw_pkg::GROUP_BITS);
    if (kind == hmw_pkg::K_BIT) begin
      itemAddr = addr + 17'(idx * hmw_pkg::GROUP_BITS);
    end
  end

  // read-modify-write value of the addressed word
  always_comb begin
    curWord = 16'h0000;
    if (itemAddr <= hmw_pkg::WORD_MAX) begin
      curWord = wordMem[itemAddr[13:0]];
    end
    unique case (attr)
      hmw_pkg::OP_SET: newWord = itemVal[15:0];
      hmw_pkg::OP_AND: newWord = curWord & itemVal[15:0];
      hmw_pkg::OP_OR: newWord = curWord | itemVal[15:0];
      hmw_pkg::OP_XOR: newWord = curWord ^ itemVal[15:0];
    endcase
  end

  assign rxByte = {hiNib, nib};

  // ---------------------------------------------------------------
  // data accumulation and write execution
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    wrEvt.valid <= 1'b0;
    if (sys_rst) begin
      wrEvt <= '0;
      acc <= 40'h0000000000;
      nd <= 4'h0;
      idx <= 7'h00;
      hiNib <= 4'h0;
      nibPhase <= 1'b0;
      pend <= 8'h00;
      havePend <= 1'b0;
    end else if (state != S_DATA) begin
      acc <= 40'h0000000000;
      nd <= 4'h0;
      idx <= 7'h00;
      nibPhase <= 1'b0;
      havePend <= 1'b0;
    end else if (kind == hmw_pkg::K_STR) begin
      // bytes are held one step so a trailing checksum is never written
      if (rxFire && isHex) begin
        nibPhase <= !nibPhase;
        hiNib <= nib;
        if (nibPhase) begin
          pend <= rxByte;
          havePend <= 1'b1;
          if (havePend) begin
            idx <= idx + 7'h01;
          end
          if (havePend && idx < hmw_pkg::STR_LEN) begin
            wrEvt <= {1'b1, hmw_pkg::K_STR, addr, 16'h0000, 1'b0, idx,
                      pend, 16'hffff};
          end
        end
      end else if (endFrame && !csum && havePend &&
                   idx < hmw_pkg::STR_LEN) begin
        wrEvt <= {1'b1, hmw_pkg::K_STR, addr, 16'h0000, 1'b0, idx,
                  pend, 16'hffff};
      end
    end else if (rxFire && isHex) begin
      acc <= {acc[35:0], nib};
      nd <= nd + 4'h1;
    end else if (itemEnd) begin
      acc <= 40'h0000000000;
      nd <= 4'h0;
      if (itemHas) begin
        idx <= idx + 7'h01;
      end
      unique case (kind)
        hmw_pkg::K_WORD: begin
          if (itemHas && idx < cnt && itemAddr <= hmw_pkg::WORD_MAX) begin
            wordMem[itemAddr[13:0]] <= newWord;
            wrEvt <= {1'b1, hmw_pkg::K_WORD, itemAddr, 16'h0000,
                      newWord, 16'hffff};
          end
        end
        hmw_pkg::K_NUM: begin
          // clock tables finish normally but stay untouched
          if (itemHas && idx < cnt && itemAddr <= hmw_pkg::NUM_MAX &&
              !(itemAddr >= hmw_pkg::NUM_RO_LO &&
                itemAddr <= hmw_pkg::NUM_RO_HI)) begin
            wrEvt <= {1'b1, hmw_pkg::K_NUM, itemAddr, itemVal, 16'hffff};
          end
        end
        hmw_pkg::K_BIT: begin
          // groups past (count-1)/16+1 are ignored
          if (itemHas && 7'(idx * hmw_pkg::GROUP_BITS) < cnt) begin
            wrEvt.valid <= 1'b1;
            wrEvt.kind <= hmw_pkg::K_BIT;
            wrEvt.addr <= itemAddr;
            wrEvt.data <= {16'h0000, itemVal[15:0]};
            wrEvt.mask <= bitRem >= hmw_pkg::GROUP_BITS ? 16'hffff :
                          16'((17'h00001 << bitRem) - 17'h00001);
          end
        end
        default: wrEvt.valid <= 1'b0;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // acknowledgement sender
  // ---------------------------------------------------------------
  function automatic logic [7:0] respByte(input logic [2:0] i,
                                          input hmw_pkg::hmw_kind_t k);
    logic [7:0] hdr;
    logic [15:0] cs;
    hdr = hmw_pkg::CH_M;
    cs = hmw_pkg::CS_WORD;
    unique case (k)
      hmw_pkg::K_WORD: hdr = hmw_pkg::CH_M;
      hmw_pkg::K_NUM: begin
        hdr = hmw_pkg::CH_N;
        cs = hmw_pkg::CS_NUM;
      end
      hmw_pkg::K_STR: begin
        hdr = hmw_pkg::CH_S;
        cs = hmw_pkg::CS_STR;
      end
      hmw_pkg::K_BIT: begin
        hdr = hmw_pkg::CH_B;
        cs = hmw_pkg::CS_BIT;
      end
    endcase
    unique case (i)
      3'h0: respByte = hmw_pkg::CH_ESC;
      3'h1: respByte = hmw_pkg::CH_W;
      3'h2: respByte = hdr;
      3'h3: respByte = hmw_pkg::CH_ZERO;
      3'h4: respByte = hmw_pkg::CH_ZERO;
      3'h5: respByte = cs[15:8];
      3'h6: respByte = cs[7:0];
      3'h7: respByte = hmw_pkg::CH_CR;
    endcase
  endfunction

  // one byte offered at a time, held until txReady
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      txValid <= 1'b0;
      txData <= 8'h00;
      txIdx <= 3'h0;
    end else if (state == S_RESP) begin
      if (!txValid) begin
        txValid <= 1'b1;
        txData <= respByte(txIdx, kind);
      end else if (txReady) begin
        txIdx <= txIdx + 3'h1;
        txData <= respByte(txIdx + 3'h1, kind);
        if (txIdx == hmw_pkg::RESP_LAST) begin
          txValid <= 1'b0;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // apb register slave, answers in the first access cycle
  // ---------------------------------------------------------------
  assign apbSetup = psel && !penable;
  assign apbHit = paddr == hmw_pkg::REG_CTRL || paddr == hmw_pkg::REG_STAT;

  // read data and error prepared during setup
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= apbSetup;
      pslverr <= apbSetup && !apbHit;
      prdata <= 32'h00000000;
      if (apbSetup && !pwrite && paddr == hmw_pkg::REG_CTRL) begin
        prdata[hmw_pkg::CTRL_RESP] <= respEn;
      end else if (apbSetup && !pwrite && paddr == hmw_pkg::REG_STAT) begin
        prdata[hmw_pkg::STAT_BUSY] <= state != S_IDLE;
        prdata[hmw_pkg::STAT_DONE +: 8] <= doneCnt;
        prdata[hmw_pkg::STAT_ERR +: 8] <= errCnt;
      end
    end
  end

  // response switch written in the completing access cycle
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      respEn <= 1'b0;
    end else if (psel && penable && pready && pwrite &&
                 paddr == hmw_pkg::REG_CTRL) begin
      respEn <= pwdata[hmw_pkg::CTRL_RESP];
    end
  end

endmodule

/* hw/hmw_pkg.sv */
// package: constants, types and carriers of the host write command handler
package hmw_pkg;

  // ---------------------------------------------------------------
  // ascii characters of the link
  // ---------------------------------------------------------------
  localparam logic [7:0] CH_ESC = 8'h1b; // frame start
  localparam logic [7:0] CH_CR = 8'h0d; // frame end
  localparam logic [7:0] CH_COMMA = 8'h2c; // item separator
  localparam logic [7:0] CH_W = 8'h57; // first header letter
  localparam logic [7:0] CH_M = 8'h4d; // word memory header
  localparam logic [7:0] CH_N = 8'h4e; // numeral table header
  localparam logic [7:0] CH_S = 8'h53; // string table header
  localparam logic [7:0] CH_B = 8'h42; // bit table header
  localparam logic [7:0] CH_ZERO = 8'h30; // digit zero
  localparam logic [7:0] CH_NINE = 8'h39; // digit nine
  localparam logic [7:0] CH_UA = 8'h41; // upper case a
  localparam logic [7:0] CH_UF = 8'h46; // upper case f
  localparam logic [7:0] CH_LA = 8'h61; // lower case a
  localparam logic [7:0] CH_LF = 8'h66; // lower case f
  localparam logic [3:0] ALPHA_ADJ = 4'h9; // letter nibble correction

  // ---------------------------------------------------------------
  // fixed acknowledgement checksums, two ascii characters each
  // ---------------------------------------------------------------
  localparam logic [15:0] CS_WORD = 16'h3146; // "1F"
  localparam logic [15:0] CS_NUM = 16'h3230; // "20"
  localparam logic [15:0] CS_STR = 16'h3235; // "25"
  localparam logic [15:0] CS_BIT = 16'h3134; // "14"
  localparam logic [2:0] RESP_LAST = 3'h7; // eight response bytes

  // ---------------------------------------------------------------
  // address and count limits
  // ---------------------------------------------------------------
  localparam int WORD_DEPTH = 10000; // word memory entries
  localparam logic [16:0] WORD_MAX = 17'h0270f; // word 9999
  localparam logic [16:0] NUM_MAX = 17'h007cf; // table 1999
  localparam logic [16:0] STR_MAX = 17'h001f3; // table 499
  localparam logic [16:0] BIT_MAX = 17'h003e7; // table 999
  localparam logic [16:0] NUM_RO_LO = 17'h000f7; // table 247
  localparam logic [16:0] NUM_RO_HI = 17'h000fd; // table 253
  localparam logic [6:0] WORD_CNT_MAX = 7'h32; // 50 words
  localparam logic [6:0] NUM_CNT_MAX = 7'h14; // 20 tables
  localparam logic [6:0] BIT_CNT_ZERO = 7'h64; // count 00 means 100
  localparam logic [6:0] STR_LEN = 7'h28; // 40 characters
  localparam logic [6:0] GROUP_BITS = 7'h10; // bits per hex group
  localparam logic [1:0] ADDR_LAST = 2'h3; // four address digits
  localparam logic [1:0] CNT_LAST = 2'h1; // two count digits
  localparam logic [3:0] CS_DIGITS = 4'h2; // checksum characters

  // ---------------------------------------------------------------
  // apb register map
  // ---------------------------------------------------------------
  localparam logic [11:0] REG_CTRL = 12'h000; // control register
  localparam logic [11:0] REG_STAT = 12'h004; // status register
  localparam int CTRL_RESP = 0; // acknowledgement enable bit
  localparam int STAT_BUSY = 0; // frame in progress bit
  localparam int STAT_DONE = 8; // done counter lsb
  localparam int STAT_ERR = 16; // error counter lsb

  // command kinds, one-hot
  typedef enum logic [3:0] {
    K_WORD = 4'h1,
    K_NUM = 4'h2,
    K_STR = 4'h4,
    K_BIT = 4'h8
  } hmw_kind_t;

  // write attribute, taken from mode digit bits 2:1
  typedef enum logic [1:0] {
    OP_SET = 2'h0,
    OP_AND = 2'h1,
    OP_OR = 2'h2,
    OP_XOR = 2'h3
  } hmw_op_t;

  // one applied write as seen outside the block
  typedef struct packed {
    logic valid;
    hmw_kind_t kind;
    logic [16:0] addr;
    logic [31:0] data;
    logic [15:0] mask;
  } hmw_wr_t;

endpackage

/* testbench/hmw_cmd_top_properties.sv */
// checker: port properties of the host write command handler
`timescale 1ns/1ps
module hmw_cmd_top_properties (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic rxReady,
  input wire logic txValid,
  input wire logic [7:0] txData,
  input wire logic txReady,
  input wire hmw_pkg::hmw_wr_t wrEvt,
  input wire logic pslverr
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // -------------------------------------------
  // acknowledgement framing and write events
  // -------------------------------------------
  a_ack_opens: assert property (
    $rose(txValid) |-> txData == 8'h1b)
    else $error("ack does not open with esc");
  a_ack_holds: assert property (
    txValid && !txReady |=> txValid && $stable(txData))
    else $error("ack byte dropped before taken");
  a_ack_header: assert property (
    txValid && txReady && txData == 8'h1b |=> txData == 8'h57)
    else $error("ack header letter wrong");
  a_ack_closes: assert property (
    txValid && txReady && txData == 8'h0d |=> !txValid)
    else $error("ack runs past cr");
  a_rx_blocked: assert property (
    txValid |-> !rxReady)
    else $error("bytes taken during ack");
  a_word_range: assert property (
    wrEvt.valid && wrEvt.kind == hmw_pkg::K_WORD |->
      wrEvt.addr <= 17'h0270f)
    else $error("word write past 9999");
  a_num_skip: assert property (
    wrEvt.valid && wrEvt.kind == hmw_pkg::K_NUM |->
      !(wrEvt.addr inside {[17'h000f7:17'h000fd]}))
    else $error("clock table written");
  a_bit_mask: assert property (
    wrEvt.valid && wrEvt.kind == hmw_pkg::K_BIT |-> wrEvt.mask[0] &&
      (wrEvt.mask & (wrEvt.mask + 16'h1)) == 16'h0)
    else $error("bit mask not filled from bit 0");
  cover property ($rose(txValid));
  cover property (wrEvt.valid && wrEvt.kind == hmw_pkg::K_STR);
  cover property (pslverr);
endmodule
bind hmw_cmd_top hmw_cmd_top_properties i_props (.sys_clk, .sys_rst,
  .rxReady, .txValid, .txData, .txReady, .wrEvt, .pslverr);

/* testbench/hmw_cmd_top_tb.sv */
// testbench: host write command handler, frames and apb calls
`timescale 1ns/1ps
module hmw_cmd_top_tb;
  localparam logic [63:0] WM = 64'h1b574d303031460d; // word ack
  logic sys_clk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, rxValid, rxReady, txValid, txReady, pready;
  logic pslverr, er;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [7:0] rxData, txData;
  hmw_pkg::hmw_wr_t wrEvt;
  hmw_pkg::hmw_wr_t ev[$]; // writes seen in one frame
  int miscompares = 0, samplesChecked = 0;
  string ops[3] = '{"2", "5", "7"}; // and, or with sum, xor with sum
  logic [15:0] res[3] = '{16'h1014, 16'h1234, 16'h0000};
  string s;
  always #2 sys_clk = ~sys_clk;
  hmw_cmd_top i_dut (.sys_clk, .sys_rst, .rxValid, .rxData, .rxReady,
    .txValid, .txData, .txReady, .wrEvt, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr);
  hmw_host_model i_host (.sys_clk, .rxReady, .rxValid, .rxData,
    .txValid, .txData, .txReady);
  always @(posedge sys_clk) if (wrEvt.valid === 1'b1) ev.push_back(wrEvt);
  task automatic check(string nm, logic [71:0] seen, exp);
    samplesChecked++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one apb transfer: setup, then access until pready
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask
  // send a frame, let the link settle, check ack and write count
  task automatic frame(string f, logic [63:0] a, int n);
    ev.delete();
    i_host.ack = 64'h0;
    i_host.send(f);
    for (int k = 0; k < 80 && !(k > 4 && rxReady && !txValid); k++)
      @(posedge sys_clk);
    check("ack", i_host.ack, a);
    check("writes", ev.size(), n);
    $display("test %s done", f.substr(1, 2));
  endtask
  task automatic evt(int i, logic [3:0] k, int a, logic [31:0] d);
    check("event", {ev[i].kind, ev[i].addr, ev[i].data}, {k, a[16:0], d});
  endtask
  task automatic stop_test();
    $display("checked %0d mismatches %0d", samplesChecked, miscompares);
    if (miscompares == 0 && samplesChecked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    #100us;
    miscompares++;
    stop_test();
  end
  initial begin
    repeat (20) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    apb(1'b0, 12'h000, 32'h0);
    check("ctrl reset", rd, 32'h0);
    apb(1'b0, 12'h008, 32'h0);
    check("unmapped", er, 1'b1);
    apb(1'b1, 12'h000, 32'h1);
    frame("\033WM1999902FFFF,A00\015", WM, 1);
    evt(0, 4'h1, 9999, 32'hffff);
    frame("\033WM800053456\015", WM, 1);
    foreach (ops[i]) begin
      s = (i == 0) ? "" : "00";
      frame({"\033WM", ops[i], "0005011234", s, "\015"}, WM, 1);
      evt(0, 4'h1, 5, {16'h0, res[i]});
    end
    frame("\033WN00246021,FFFFFFFF\015", 64'h1b574e303032300d, 1);
    evt(0, 4'h2, 246, 32'h1);
    frame("\033WN9001212345678AB\015", 64'h1b574e303032300d, 1);
    evt(0, 4'h2, 12, 32'h12345678);
    frame("\033WB0005120FFFF,000F\015", 64'h1b5742303031340d, 2);
    evt(1, 4'h8, 67, 32'hf);
    check("mask", ev[1].mask, 16'h000f);
    s = "";
    repeat (40) s = {s, "41"};
    frame({"\033WS00003", s, "\015"}, 64'h1b5753303032350d, 40);
    evt(39, 4'h4, 3, 32'h2741);
    apb(1'b1, 12'h000, 32'h0);
    frame("\033WM8000112\015", 64'h0, 1);
    frame("\033WX0\015", 64'h0, 0);
    frame("\033WM0000051\015", 64'h0, 0);
    apb(1'b0, 12'h004, 32'h0);
    check("rejects", rd[23:16], 8'h02);
    check("done idle", rd[15:0], 16'h0a00);
    stop_test();
  end
endmodule

/* testbench/hmw_host_model.sv */
// partner model: host that sends frames and takes responses
`timescale 1ns/1ps
module hmw_host_model (
  input wire logic sys_clk,
  input wire logic rxReady,
  output logic rxValid,
  output logic [7:0] rxData,
  input wire logic txValid,
  input wire logic [7:0] txData,
  output logic txReady
);
  logic [63:0] ack = 64'h0; // last eight response bytes
  initial begin
    rxValid = 1'b0;
    rxData = 8'h00;
    txReady = 1'b0;
  end
  // each byte held until the edge that takes it
  task automatic send(input string s);
    for (int i = 0; i < s.len(); i++) begin
      rxValid <= 1'b1;
      rxData <= s[i];
      do @(posedge sys_clk); while (rxReady !== 1'b1);
    end
    rxValid <= 1'b0;
    rxData <= ~s[s.len()-1]; // released line shows the inverse
  endtask
  // take response bytes, stalling every other cycle
  always @(posedge sys_clk) begin
    if (txValid && txReady)
      ack <= {ack[55:0], txData};
    txReady <= ~txReady;
  end
endmodule
